// File: core/pts_map.svh
// Register offsets, field positions, error codes and timing counts of the pulse train port.
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH
// ============================================================
// Register byte offsets
`define PTS_CMD_OFF       8'h00
`define PTS_CFG_OFF       8'h04
`define PTS_TARGET_OFF    8'h08
`define PTS_RATE_OFF      8'h0C
`define PTS_COUNT_OFF     8'h10
`define PTS_MONTIME_OFF   8'h14
`define PTS_STATUS_OFF    8'h18
`define PTS_FREQ_OFF      8'h1C
`define PTS_REMAIN_OFF    8'h20
// ============================================================
// Command and configuration bit positions
`define PTS_CMD_START     0
`define PTS_CMD_STOP      1
`define PTS_CMD_ORIGIN    2
`define PTS_CFG_INDEP     0
`define PTS_CFG_ACCEL     1
`define PTS_CFG_REVERSE   2
`define PTS_CFG_REV_LIMIT 3
`define PTS_CFG_USE_PROX  4
// ============================================================
// Error codes
`define PTS_ERR_NONE      16'h0000
`define PTS_ERR_LIM_FWD   16'h0100
`define PTS_ERR_LIM_REV   16'h0101
`define PTS_ERR_REVERSAL  16'h0206
`define PTS_ERR_TIMEOUT   16'h0300
// ============================================================
// Timing
`define PTS_CLK_PERIOD_NS 100
`define PTS_CLK_HZ        25'h0989680
`define PTS_RAMP_TIME_NS  1000000
`define PTS_RAMP_CYCLES   (`PTS_RAMP_TIME_NS / `PTS_CLK_PERIOD_NS)
`endif

// File: core/pts_pkg.sv
// Types shared by the pulse train port.
`default_nettype none

package pts_pkg;
	// ============================================================
	// Port sequencer states.
	typedef enum logic [1:0] {PTS_IDLE, PTS_SETUP, PTS_RUN, PTS_MONITOR} pts_state_enum_type;

	// ============================================================
	// Complete state of the port, registered as one word.
	typedef struct packed {
		pts_state_enum_type state;
		logic [4:0]         cfg;
		logic [19:0]        target;
		logic [19:0]        rate;
		logic [31:0]        count;
		logic [15:0]        mon_time;
		logic [19:0]        freq;
		logic [23:0]        acc;
		logic [15:0]        ramp_cnt;
		logic [15:0]        mon_cnt;
		logic [31:0]        remaining;
		logic [15:0]        err;
		logic               pulse;
		logic               dir;
		logic               searching;
		logic               reversing;
		logic               awready;
		logic               wready;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               arready;
		logic               rvalid;
		logic [1:0]         rresp;
		logic [31:0]        rdata;
	} pts_regs_type;
endpackage : pts_pkg

`default_nettype wire

// File: core/pts_port.sv
// Pulse plus direction output port with AXI4-Lite registers.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`include "pts_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pts_port
	import pts_pkg::*;
#(
	parameter int unsigned RAMP_CYCLES = `PTS_RAMP_CYCLES
)(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Sensor inputs
	input  wire logic        limit_forward_direction,
	input  wire logic        limit_reverse_direction,
	input  wire logic        origin_proximity,
	input  wire logic        origin_input,
	input  wire logic        in_position,
	// Drive outputs
	output logic             pulse_out,
	output logic             reverse_direction_out
);
	pts_regs_type s;
	pts_regs_type n;
	logic         busy_run;
	logic         tick;
	logic         lim_search;
	logic         ref_in;
	logic         fault_rev;
	logic         fault_lim;
	logic         wr_fire;
	logic         cmd_wr;
	logic         cmd_go;
	logic [24:0]  acc_sum;
	logic [20:0]  freq_up;
	logic [20:0]  freq_dn;

	// ============================================================
	// Hazard detection and helpers from the current state.
	assign busy_run   = (s.state == PTS_SETUP) || (s.state == PTS_RUN);
	assign tick       = (s.ramp_cnt == 16'(RAMP_CYCLES - 1));
	assign lim_search = s.cfg[`PTS_CFG_REVERSE] ? limit_reverse_direction
	                                            : limit_forward_direction;
	assign ref_in     = s.cfg[`PTS_CFG_USE_PROX] ? origin_proximity : origin_input;
	assign fault_rev  = busy_run && s.searching && s.reversing && lim_search;
	assign fault_lim  = busy_run && (limit_forward_direction || limit_reverse_direction);
	assign wr_fire    = s.awready && awvalid && wvalid;
	assign cmd_wr     = wr_fire && (awaddr == `PTS_CMD_OFF) && (wstrb == 4'hF);
	assign cmd_go     = cmd_wr && !wdata[`PTS_CMD_STOP]
	                    && (wdata[`PTS_CMD_START] || wdata[`PTS_CMD_ORIGIN]);
	// Twice the frequency is added so each overflow is one half period.
	assign acc_sum    = {1'b0, s.acc} + {4'h0, s.freq, 1'b0};
	assign freq_up    = {1'b0, s.freq} + {1'b0, s.rate};
	assign freq_dn    = {1'b0, s.freq} - {1'b0, s.rate};

	// ============================================================
	// Next-state logic: pulse engine, hazards, then bus commands.
	always_comb
	begin
		n          = s;
		n.awready  = 1'b0;
		n.wready   = 1'b0;
		n.arready  = 1'b0;
		n.ramp_cnt = tick ? 16'h0000 : s.ramp_cnt + 16'h0001;

		unique case (s.state)
			PTS_IDLE:
			begin
				n.pulse = 1'b0;
			end
			PTS_SETUP:
			begin
				// Direction already settled one cycle before any rising edge.
				if (s.cfg[`PTS_CFG_INDEP] && (s.remaining == 32'h0000_0000))
				begin
					n.state = (s.mon_time != 16'h0000) ? PTS_MONITOR : PTS_IDLE;
					n.freq  = 20'h00000;
				end
				else
				begin
					n.state = PTS_RUN;
				end
				n.mon_cnt = 16'h0000;
			end
			PTS_RUN:
			begin
				// Ramp toward the target once per ramp interval.
				if (s.cfg[`PTS_CFG_ACCEL] && tick)
				begin
					if (s.rate == 20'h00000)
						n.freq = s.target;
					else if ((s.freq < s.target) && (freq_up < {1'b0, s.target}))
						n.freq = freq_up[19:0];
					else if ((s.freq > s.target) && (freq_dn > {1'b0, s.target}))
						n.freq = freq_dn[19:0];
					else
						n.freq = s.target;
				end
				// Phase accumulator; a rising edge is one counted pulse.
				if (s.freq != 20'h00000)
				begin
					if (acc_sum >= `PTS_CLK_HZ)
					begin
						n.acc   = 24'(acc_sum - `PTS_CLK_HZ);
						n.pulse = !s.pulse;
						if (!s.pulse)
							n.remaining = s.remaining - 32'h0000_0001;
						else if (s.cfg[`PTS_CFG_INDEP] && (s.remaining == 32'h0000_0000))
						begin
							// Last pulse has completed its high half.
							n.state   = (s.mon_time != 16'h0000) ? PTS_MONITOR : PTS_IDLE;
							n.freq    = 20'h00000;
							n.mon_cnt = 16'h0000;
						end
					end
					else
					begin
						n.acc = acc_sum[23:0];
					end
				end
				// Origin search: with PTS_CFG_REV_LIMIT reverse on the reference input and stop when it clears, else stop on it.
				if (s.searching)
				begin
					if (!s.reversing && ref_in)
					begin
						if (s.cfg[`PTS_CFG_REV_LIMIT])
						begin
							n.reversing = 1'b1;
							n.dir       = !s.dir;
							n.state     = PTS_SETUP;
							n.pulse     = 1'b0;
							n.acc       = 24'h000000;
						end
						else
						begin
							// Drop the pulse too, so no half step is left behind.
							n.state     = PTS_IDLE;
							n.pulse     = 1'b0;
							n.freq      = 20'h00000;
							n.searching = 1'b0;
						end
					end
					else if (s.reversing && !ref_in)
					begin
						n.state     = PTS_IDLE;
						n.pulse     = 1'b0;
						n.freq      = 20'h00000;
						n.searching = 1'b0;
						n.reversing = 1'b0;
					end
				end
			end
			PTS_MONITOR:
			begin
				// Completion watch after the final pulse.
				if (in_position)
					n.state = PTS_IDLE;
				else if (tick)
				begin
					if ((s.mon_cnt + 16'h0001) >= s.mon_time)
					begin
						n.state = PTS_IDLE;
						n.err   = `PTS_ERR_TIMEOUT;
					end
					else
						n.mon_cnt = s.mon_cnt + 16'h0001;
				end
			end
		endcase

		// Emergency stops cut the output at the next clock edge, no ramp down.
		// All state is local, so nothing here reaches another port.
		if (fault_rev || fault_lim)
		begin
			n.state     = PTS_IDLE;
			n.pulse     = 1'b0;
			n.freq      = 20'h00000;
			n.searching = 1'b0;
			n.reversing = 1'b0;
			if (fault_rev)
				n.err = `PTS_ERR_REVERSAL;
			else if (limit_forward_direction)
				n.err = `PTS_ERR_LIM_FWD;
			else
				n.err = `PTS_ERR_LIM_REV;
		end

		// Write channel: both halves taken together, answer one cycle later.
		if (!s.bvalid && !s.awready && awvalid && wvalid)
		begin
			n.awready = 1'b1;
			n.wready  = 1'b1;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		if (wr_fire)
		begin
			n.bvalid = 1'b1;
			n.bresp  = 2'b00;
			if (wstrb == 4'hF)
			begin
				unique case (awaddr)
					`PTS_CFG_OFF:     n.cfg      = wdata[4:0];
					`PTS_TARGET_OFF:  n.target   = wdata[19:0];
					`PTS_RATE_OFF:    n.rate     = wdata[19:0];
					`PTS_COUNT_OFF:   n.count    = wdata;
					`PTS_MONTIME_OFF: n.mon_time = wdata[15:0];
					`PTS_CMD_OFF, `PTS_STATUS_OFF, `PTS_FREQ_OFF, `PTS_REMAIN_OFF: ;
					default:          n.bresp    = 2'b10;
				endcase
			end
		end

		// Commands win over hazards of the same cycle, but a start that continues a run keeps the hazard's stop to idle; a new command clears the code.
		if (cmd_wr && wdata[`PTS_CMD_STOP])
		begin
			n.state     = PTS_IDLE;
			n.pulse     = 1'b0;
			n.freq      = 20'h00000;
			n.err       = `PTS_ERR_NONE;
			n.searching = 1'b0;
			n.reversing = 1'b0;
		end
		else if (cmd_wr && (wdata[`PTS_CMD_START] || wdata[`PTS_CMD_ORIGIN]))
		begin
			n.err       = `PTS_ERR_NONE;
			n.searching = wdata[`PTS_CMD_ORIGIN];
			n.reversing = 1'b0;
			n.dir       = s.cfg[`PTS_CFG_REVERSE];
			// Fixed speed steps at once; accelerated keeps the present rate.
			n.freq      = s.cfg[`PTS_CFG_ACCEL] ? s.freq : s.target;
			// Same direction while running continues without a gap.
			if (!((s.state == PTS_RUN) && (s.dir == s.cfg[`PTS_CFG_REVERSE])))
			begin
				n.state = PTS_SETUP;
				n.pulse = 1'b0;
				n.acc   = 24'h000000;
			end
			// A step launched in the command's own cycle counts against the new count.
			n.remaining = (n.pulse && !s.pulse) ? s.count - 32'h0000_0001 : s.count;
		end

		// Read channel.
		if (!s.rvalid && !s.arready && arvalid)
			n.arready = 1'b1;
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (s.arready && arvalid)
		begin
			n.rvalid = 1'b1;
			n.rresp  = 2'b00;
			unique case (araddr)
				`PTS_CMD_OFF:     n.rdata = 32'h0000_0000;
				`PTS_CFG_OFF:     n.rdata = {27'h0000000, s.cfg};
				`PTS_TARGET_OFF:  n.rdata = {12'h000, s.target};
				`PTS_RATE_OFF:    n.rdata = {12'h000, s.rate};
				`PTS_COUNT_OFF:   n.rdata = s.count;
				`PTS_MONTIME_OFF: n.rdata = {16'h0000, s.mon_time};
				`PTS_STATUS_OFF:  n.rdata = {s.err, 11'h000, (s.state == PTS_MONITOR),
				                             s.searching, s.reversing, s.dir,
				                             (s.state != PTS_IDLE)};
				`PTS_FREQ_OFF:    n.rdata = {12'h000, s.freq};
				`PTS_REMAIN_OFF:  n.rdata = s.remaining;
				default:
				begin
					n.rdata = 32'h0000_0000;
					n.rresp = 2'b10;
				end
			endcase
		end
	end

	// ============================================================
	// State register with synchronous reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= n;
	end

	// ============================================================
	// Outputs come straight from the state register.
	assign awready               = s.awready;
	assign wready                = s.wready;
	assign bvalid                = s.bvalid;
	assign bresp                 = s.bresp;
	assign arready               = s.arready;
	assign rvalid                = s.rvalid;
	assign rresp                 = s.rresp;
	assign rdata                 = s.rdata;
	assign pulse_out             = s.pulse;
	assign reverse_direction_out = s.dir;

	// ============================================================
	// Checks.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_reverse_prox: assert property (fault_rev && s.cfg[`PTS_CFG_USE_PROX] && !cmd_wr
		|=> s.err == `PTS_ERR_REVERSAL && s.state == PTS_IDLE)
		else $error("reversal fault with proximity input not reported");
	chk_reverse_origin: assert property (fault_rev && !s.cfg[`PTS_CFG_USE_PROX] && !cmd_wr
		|=> s.err == `PTS_ERR_REVERSAL && !s.pulse)
		else $error("reversal fault on origin input not reported");
	chk_monitor_timeout: assert property (s.state == PTS_MONITOR && !in_position && tick
		&& (s.mon_cnt + 16'h0001) >= s.mon_time && !cmd_wr |=> s.err == `PTS_ERR_TIMEOUT)
		else $error("positioning timeout not flagged");
	chk_continuous_run: assert property (s.state == PTS_RUN && !s.cfg[`PTS_CFG_INDEP]
		&& !s.searching && !fault_lim && !cmd_wr |=> s.state == PTS_RUN)
		else $error("continuous output stopped without a command");
	chk_count_step: assert property ($rose(s.pulse) |-> s.state == PTS_RUN
		&& s.remaining == ($past(cmd_go) ? $past(s.count) : $past(s.remaining)) - 32'h0000_0001)
		else $error("pulse not counted");
	chk_fixed_start: assert property (cmd_wr && wdata[`PTS_CMD_START] && !wdata[`PTS_CMD_STOP]
		&& !s.cfg[`PTS_CFG_ACCEL] |=> s.freq == s.target)
		else $error("fixed-speed start did not reach target at once");
	chk_ramp_step: assert property (s.state == PTS_RUN && s.cfg[`PTS_CFG_ACCEL] && tick
		&& s.freq < s.target && s.rate != 20'h00000 && !fault_lim && !cmd_wr
		|=> s.freq > $past(s.freq) && s.freq <= s.target)
		else $error("ramp did not step toward target");
	chk_limit_stop: assert property (fault_lim && !fault_rev && !cmd_wr
		|=> s.state == PTS_IDLE && !s.pulse && (s.err == `PTS_ERR_LIM_FWD
		|| s.err == `PTS_ERR_LIM_REV))
		else $error("limit input did not stop output");
	chk_dir_hold: assert property (s.state == PTS_RUN && $past(s.state) == PTS_RUN
		|-> $stable(s.dir))
		else $error("direction changed while pulsing");
	chk_err_hold: assert property (s.err != `PTS_ERR_NONE && !cmd_wr
		|=> s.err == $past(s.err) || $past(fault_rev) || $past(fault_lim))
		else $error("error code lost without command");

	cov_fixed_run: cover property (s.state == PTS_SETUP ##1 s.state == PTS_RUN ##[1:50] $rose(s.pulse));
	cov_timeout: cover property (s.state == PTS_MONITOR ##1 s.err == `PTS_ERR_TIMEOUT);
	cov_reversal: cover property ($rose(s.reversing) ##[1:200] s.err == `PTS_ERR_REVERSAL);
endmodule : pts_port

`default_nettype wire

// File: tb/pts_drive_model.sv
// Behavioural pulse plus direction drive: counts steps and reports in-position.
`timescale 1ns/1ps
`default_nettype none

module pts_drive_model #(
	parameter int QUIET = 150
)(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Step inputs from the port
	input  wire logic pulse_out,
	input  wire logic reverse_direction_out,
	// Bench control: zero makes the drive never settle
	input  wire logic respond,
	// Status back to the port
	output logic      in_position
);
	// ============================================================
	// Step counting and settle watch
	int   pulses;
	int   dir_bad;
	int   quiet;
	logic pulse_q;
	logic dir_q;

	// A step is a rising edge; the drive settles QUIET cycles after the last one.
	// QUIET exceeds the 100-cycle step period of the 100 kHz runs, so a gap between their steps is not taken for rest.
	always_ff @(posedge aclk)
	begin
		pulse_q <= pulse_out;
		dir_q   <= reverse_direction_out;
		if (!aresetn)
		begin
			pulses      <= 0;
			dir_bad     <= 0;
			quiet       <= 0;
			in_position <= 1'b0;
		end
		else if (pulse_out && !pulse_q)
		begin
			pulses      <= pulses + 1;
			quiet       <= 0;
			in_position <= 1'b0;
			if (reverse_direction_out != dir_q)
				dir_bad <= dir_bad + 1;
		end
		else
		begin
			if (quiet < QUIET)
				quiet <= quiet + 1;
			in_position <= respond && (quiet >= QUIET);
		end
	end
endmodule : pts_drive_model

`default_nettype wire

// File: tb/pulse_train_speed_control_bench.sv
// Self-checking bench of the pulse train port driven over AXI4-Lite.
`include "pts_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pulse_train_speed_control_bench;
	// ============================================================
	// Signals
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, br, rr;
	logic        lim_f, lim_r, prox, orig, in_pos, pulse, rdir, respond;
	int          bad_count = 0;
	int          checks = 0;
	int          p0;

	// The clock runs at 10 MHz.
	always #50 aclk = ~aclk;

	pts_port #(.RAMP_CYCLES(20)) u_pts_port (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .limit_forward_direction(lim_f),
		.limit_reverse_direction(lim_r), .origin_proximity(prox),
		.origin_input(orig), .in_position(in_pos), .pulse_out(pulse),
		.reverse_direction_out(rdir));

	pts_drive_model u_pts_drive_model (.aclk(aclk), .aresetn(aresetn),
		.pulse_out(pulse), .reverse_direction_out(rdir), .respond(respond),
		.in_position(in_pos));

	// ============================================================
	// Reporting
	task automatic summarize;
		$display("Mismatches %0d of %0d checks", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ============================================================
	// Bus tasks: readiness seen at the falling edge is what the next rising edge samples.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ra, rw, rb;
		int   n;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		rb = 1'b0;
		for (n = 0; n < 100 && !rb; n++)
		begin
			@(negedge aclk);
			ra = (awready === 1'b1);
			rw = (wready === 1'b1);
			rb = (bvalid === 1'b1);
			br = bresp;
			@(posedge aclk);
			if (ra) awvalid <= 1'b0;
			if (rw) wvalid <= 1'b0;
			if (rb) bready <= 1'b0;
		end
		chk(32'(rb), 32'h1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic rg, rvl;
		int   n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		rvl = 1'b0;
		for (n = 0; n < 100 && !rvl; n++)
		begin
			@(negedge aclk);
			rg  = (arready === 1'b1);
			rvl = (rvalid === 1'b1);
			rv  = rdata;
			rr  = rresp;
			@(posedge aclk);
			if (rg) arvalid <= 1'b0;
			if (rvl) rready <= 1'b0;
		end
		chk(32'(rvl), 32'h1);
	endtask : rd

	// Reads the error code field of the status word.
	task automatic err_is(input logic [15:0] e);
		rd(`PTS_STATUS_OFF);
		chk(32'(rv[31:16]), 32'(e));
	endtask : err_is

	// Writes configuration and target, then issues a command.
	task automatic go(input logic [31:0] cfg, input logic [31:0] tgt, input logic [31:0] cmd);
		wr(`PTS_CFG_OFF, cfg);
		wr(`PTS_TARGET_OFF, tgt);
		wr(`PTS_CMD_OFF, cmd);
	endtask : go

	// ============================================================
	// Watchdog: the tests need about 12000 cycles.
	initial
	begin
		#(100 * 60000);
		bad_count++;
		summarize();
	end

	// ============================================================
	// Main sequence
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, lim_f, lim_r, prox, orig} = '0;
		respond = 1'b1;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`PTS_STATUS_OFF);
		chk(rv, 32'h0);
		rd(8'h40);
		chk({rv[29:0], rr}, 32'h2);
		wr(8'h40, 32'h1);
		chk(32'(br), 32'h2);
		// Fixed speed continuous run at 100 kHz: one step per 100 cycles, no count.
		p0 = u_pts_drive_model.pulses;
		go(32'h0, 32'h186A0, 32'h1);
		repeat (4000) @(posedge aclk);
		p0 = u_pts_drive_model.pulses - p0;
		chk(32'(p0 >= 39 && p0 <= 41), 32'h1);
		rd(`PTS_FREQ_OFF);
		chk(rv, 32'h186A0);
		err_is(`PTS_ERR_NONE);
		// A forward limit stops at once and the code stays until the next command.
		lim_f <= 1'b1;
		repeat (3) @(posedge aclk);
		p0 = u_pts_drive_model.pulses;
		repeat (300) @(posedge aclk);
		chk(32'(u_pts_drive_model.pulses - p0), 32'h0);
		lim_f <= 1'b0;
		err_is(`PTS_ERR_LIM_FWD);
		wr(`PTS_CMD_OFF, 32'h2);
		err_is(`PTS_ERR_NONE);
		// Reverse run: direction is set, then the reverse limit reports its own code.
		go(32'h4, 32'h186A0, 32'h1);
		repeat (300) @(posedge aclk);
		chk(32'(rdir), 32'h1);
		lim_r <= 1'b1;
		repeat (3) @(posedge aclk);
		lim_r <= 1'b0;
		err_is(`PTS_ERR_LIM_REV);
		// Independent runs give exactly the commanded count, zero included.
		for (int i = 0; i < 3; i++)
		begin
			wr(`PTS_COUNT_OFF, (i == 0) ? 32'h0 : (i == 1) ? 32'h1 : 32'h5);
			wr(`PTS_MONTIME_OFF, 32'h0);
			p0 = u_pts_drive_model.pulses;
			go(32'h1, 32'h186A0, 32'h1);
			repeat (1000) @(posedge aclk);
			chk(32'(u_pts_drive_model.pulses - p0), (i == 0) ? 0 : (i == 1) ? 1 : 5);
			rd(`PTS_STATUS_OFF);
			chk(32'(rv[0]), 32'h0);
		end
		// Positioning watch: a settling drive passes, a silent one times out.
		for (int i = 0; i < 2; i++)
		begin
			respond <= (i == 0);
			wr(`PTS_COUNT_OFF, 32'h3);
			wr(`PTS_MONTIME_OFF, 32'hA);
			go((i == 0) ? 32'h1 : 32'h5, 32'h186A0, 32'h1);
			repeat (1200) @(posedge aclk);
			err_is((i == 0) ? `PTS_ERR_NONE : `PTS_ERR_TIMEOUT);
		end
		respond <= 1'b1;
		// Accelerated start ramps in steps of the rate until the target.
		wr(`PTS_RATE_OFF, 32'h2710);
		go(32'h2, 32'hC350, 32'h1);
		rd(`PTS_FREQ_OFF);
		chk(32'(rv < 32'hC350 && rv % 32'h2710 == 0), 32'h1);
		repeat (50) @(posedge aclk);
		rd(`PTS_FREQ_OFF);
		chk(32'(rv > 0 && rv < 32'hC350 && rv % 32'h2710 == 0), 32'h1);
		repeat (300) @(posedge aclk);
		rd(`PTS_FREQ_OFF);
		chk(rv, 32'hC350);
		// Origin search with reversal: proximity first, then the origin input alone.
		for (int i = 0; i < 2; i++)
		begin
			go((i == 0) ? 32'h18 : 32'h8, 32'h186A0, 32'h4);
			repeat (200) @(posedge aclk);
			prox <= (i == 0);
			orig <= (i == 1);
			repeat (200) @(posedge aclk);
			rd(`PTS_STATUS_OFF);
			chk(32'(rv[2]), 32'h1);
			lim_f <= 1'b1;
			repeat (5) @(posedge aclk);
			p0 = u_pts_drive_model.pulses;
			repeat (200) @(posedge aclk);
			chk(32'(u_pts_drive_model.pulses - p0), 32'h0);
			err_is(`PTS_ERR_REVERSAL);
			{lim_f, prox, orig} <= '0;
			wr(`PTS_CMD_OFF, 32'h2);
		end
		chk(32'(u_pts_drive_model.dir_bad), 32'h0);
		summarize();
	end
endmodule : pulse_train_speed_control_bench

`default_nettype wire
